// ### bench/tb_alu_subtract_swap_xor.sv
`timescale 1ns/1ps

module tb_alu_subtract_swap_xor;
    import asx_pkg::*;

    // ------------------------------------------------------------
    // design ports
    // ------------------------------------------------------------
    logic       ref_clk_i   = 1'b0;     // 50 ns core clock
    logic       rst_i       = 1'b1;     // synchronous reset
    logic       op_valid_i  = 1'b0;     // execute strobe
    logic [2:0] op_code_i   = 3'h0;     // operation
    logic [7:0] literal_i   = 8'h00;    // literal operand
    logic [6:0] reg_addr_i  = 7'h00;    // file register address
    logic       dest_i      = 1'b0;     // destination select
    logic [7:0] reg_rdata_i = 8'h00;    // register file read data
    wire        reg_we_o;
    wire  [6:0] reg_waddr_o;
    wire  [7:0] reg_wdata_o;
    wire  [7:0] acc_o;
    wire        carry_o;
    wire        nibble_carry_flag_o;
    wire        zero_o;

    // ------------------------------------------------------------
    // expected state and counters
    // ------------------------------------------------------------
    logic [7:0] e_acc = 8'h00;          // expected accumulator
    logic       e_c   = 1'b0;           // expected carry
    logic       e_nc  = 1'b0;           // expected nibble carry
    logic       e_z   = 1'b0;           // expected null flag
    logic       e_we  = 1'b0;           // expected write strobe
    logic [6:0] e_wa  = 7'h00;          // expected write address
    logic [7:0] e_wd  = 8'h00;          // expected write data
    int         bad_count       = 0;
    int         samples_checked = 0;

    always #25 ref_clk_i = ~ref_clk_i;

    asx_alu i_dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
        .op_code_i(op_code_i), .literal_i(literal_i), .reg_addr_i(reg_addr_i),
        .dest_i(dest_i), .reg_rdata_i(reg_rdata_i), .reg_we_o(reg_we_o),
        .reg_waddr_o(reg_waddr_o), .reg_wdata_o(reg_wdata_o), .acc_o(acc_o),
        .carry_o(carry_o), .nibble_carry_flag_o(nibble_carry_flag_o), .zero_o(zero_o)
    );

    // ------------------------------------------------------------
    // comparison helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // outputs are looked at one settle step after the edge that updates them
    task automatic check_all();
        check(acc_o, e_acc);
        check({7'h00, carry_o}, {7'h00, e_c});
        check({7'h00, nibble_carry_flag_o}, {7'h00, e_nc});
        check({7'h00, zero_o}, {7'h00, e_z});
        check({7'h00, reg_we_o}, {7'h00, e_we});
        check({1'b0, reg_waddr_o}, {1'b0, e_wa});
        check(reg_wdata_o, e_wd);
    endtask

    // issue one op, advance the reference state, compare after the answer edge
    task automatic exec(input logic [2:0] op, input logic [7:0] lit,
                        input logic [6:0] addr, input logic dest, input logic [7:0] rd);
        logic [7:0] src;
        logic [7:0] res;
        op_valid_i  = 1'b1;
        op_code_i   = op;
        literal_i   = lit;
        reg_addr_i  = addr;
        dest_i      = dest;
        reg_rdata_i = rd;
        src = (op == ASX_OP_LIT_SUB || op == ASX_OP_LIT_XOR) ? lit : rd;
        res = src;
        e_we = 1'b0;
        if (op == ASX_OP_LIT_SUB || op == ASX_OP_REG_SUB) begin
            res  = src - e_acc;
            e_c  = (src >= e_acc);
            e_nc = (src[3:0] >= e_acc[3:0]);
        end else if (op == ASX_OP_SWAP) begin
            res = {src[3:0], src[7:4]};
        end else begin
            res = src ^ e_acc;
        end
        if (op inside {3'h1, 3'h2, 3'h4, 3'h5}) e_z = (res == ASX_ZERO);
        if (op inside {3'h2, 3'h3, 3'h4} && dest == ASX_DEST_REG) begin
            e_we = 1'b1;
            e_wa = addr;
            e_wd = res;
        end else if (op inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}) begin
            e_acc = res;
        end
        @(posedge ref_clk_i);
        #1;
        check_all();
    endtask

    // strobe low with a register op on the bus: nothing may happen
    task automatic idle();
        op_valid_i = 1'b0;
        op_code_i  = ASX_OP_REG_SUB;
        dest_i     = ASX_DEST_REG;
        e_we       = 1'b0;
        @(posedge ref_clk_i);
        #1;
        check_all();
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_walk();
        exec(ASX_OP_LIT_XOR, 8'h01, 7'h00, ASX_DEST_REG, 8'hAA);
        exec(ASX_OP_REG_SUB, 8'h00, 7'h05, ASX_DEST_REG, 8'h10);
        idle();
    endtask

    // zero result, borrow from both nibble and byte, minuend below subtrahend
    task automatic s_sub_bounds();
        exec(ASX_OP_LIT_SUB, 8'h01, 7'h00, ASX_DEST_REG, 8'h00);
        exec(ASX_OP_LIT_XOR, 8'h80, 7'h00, ASX_DEST_ACC, 8'h00);
        exec(ASX_OP_LIT_SUB, 8'h7F, 7'h00, ASX_DEST_ACC, 8'h00);
        exec(ASX_OP_REG_SUB, 8'h00, ASX_ADDR_MAX, ASX_DEST_ACC, 8'h00);
        exec(ASX_OP_LIT_SUB, 8'hFF, 7'h00, ASX_DEST_ACC, 8'h00);
        idle();
    endtask

    // back-to-back swaps to both destinations keep every flag
    task automatic s_swap();
        exec(ASX_OP_SWAP, 8'h00, ASX_ADDR_MAX, ASX_DEST_REG, 8'h3C);
        exec(ASX_OP_SWAP, 8'h00, 7'h00, ASX_DEST_ACC, 8'hA5);
        idle();
    endtask

    // register xor to both destinations, carries must stay
    task automatic s_xor();
        exec(ASX_OP_REG_XOR, 8'h00, 7'h11, ASX_DEST_REG, 8'h5A);
        exec(ASX_OP_REG_XOR, 8'h00, 7'h22, ASX_DEST_ACC, 8'hFF);
        exec(ASX_OP_LIT_XOR, 8'hA5, 7'h33, ASX_DEST_REG, 8'h00);
        idle();
    endtask

    // idle and unknown codes leave all state alone
    task automatic s_ignored();
        exec(ASX_OP_NONE, 8'h12, 7'h01, ASX_DEST_REG, 8'h34);
        exec(3'h6, 8'h12, 7'h01, ASX_DEST_REG, 8'h34);
        exec(3'h7, 8'h12, 7'h01, ASX_DEST_ACC, 8'h34);
        idle();
    endtask

    // reset in mid-run clears accumulator, flags and write-back port
    task automatic s_mid_reset();
        exec(ASX_OP_LIT_SUB, 8'h40, 7'h00, ASX_DEST_ACC, 8'h00);
        rst_i      = 1'b1;
        op_valid_i = 1'b0;
        @(posedge ref_clk_i);
        #1;
        {e_acc, e_c, e_nc, e_z, e_we, e_wa, e_wd} = '0;
        check_all();
        rst_i = 1'b0;
        exec(ASX_OP_REG_SUB, 8'h00, 7'h09, ASX_DEST_REG, 8'h00);
        idle();
    endtask

    // ------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk_i);
        #1;
        check_all();
        rst_i = 1'b0;
        s_walk();
        s_sub_bounds();
        s_swap();
        s_xor();
        s_ignored();
        s_mid_reset();
        end_of_test();
    end

endmodule // tb_alu_subtract_swap_xor

// ### hdl/asx_alu.sv
`timescale 1ns/1ps

// Behaviour
// - literal minus accumulator into accumulator, all flags
// - register minus accumulator, all flags, address 0..127
// - destination bit: 0 accumulator, 1 file register
// - swap nibbles, no flag changes
// - register xor accumulator, only zero flag
// - literal xor accumulator into accumulator, zero flag
module asx_alu
    import asx_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // instruction from the decoder
    input  wire logic       op_valid_i,     // one-cycle execute strobe
    input  wire logic [2:0] op_code_i,      // asx_op_t code
    input  wire logic [7:0] literal_i,      // eight-bit literal k
    input  wire logic [6:0] reg_addr_i,     // file register address
    input  wire logic       dest_i,         // destination select
    // file register read port (same clock domain)
    input  wire logic [7:0] reg_rdata_i,    // contents of addressed register
    // file register write-back
    output logic            reg_we_o,       // one-cycle write strobe
    output logic      [6:0] reg_waddr_o,    // write address
    output logic      [7:0] reg_wdata_o,    // write data
    // architectural state
    output logic      [7:0] acc_o,          // accumulator
    output logic            carry_o,        // carry / not-borrow
    output logic            nibble_carry_flag_o,
    output logic            zero_o          // result-null flag
);

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    logic [7:0] acc_reg,   acc_next;        // accumulator
    logic       carry_reg, carry_next;      // carry flag
    logic       nc_reg,    nc_next;         // nibble carry flag
    logic       z_reg,     z_next;          // zero flag
    logic       we_reg,    we_next;         // write-back strobe
    logic [6:0] wa_reg,    wa_next;         // write-back address
    logic [7:0] wd_reg,    wd_next;         // write-back data

    // ------------------------------------------------------------
    // shared subtractor
    // ------------------------------------------------------------
    logic       is_lit_sub;                 // literal form selects k as minuend
    logic [7:0] minuend;                    // k or f
    logic [7:0] diff;                       // minuend - acc
    logic       sub_c;                      // no borrow out of bit 7
    logic       sub_nc;                     // no borrow out of bit 3
    asx_op_t    op;                         // decoded operation

    assign op         = asx_op_t'(op_code_i);
    assign is_lit_sub = (op == ASX_OP_LIT_SUB);
    assign minuend    = is_lit_sub ? literal_i : reg_rdata_i;

    // one subtractor serves both forms, saving an 8-bit adder
    asx_sub u_sub (
        .minuend_i   (minuend),
        .subtrahend_i(acc_reg),
        .diff_o      (diff),
        .carry_o     (sub_c),
        .nib_carry_o (sub_nc)
    );

    // zero test used by every flag-updating operation
    function automatic logic is_null(input logic [7:0] v);
        return v == ASX_ZERO;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] res;                    // operation result
        logic       to_reg;                 // route to file register
        res        = ASX_ZERO;
        to_reg     = 1'b0;
        acc_next   = acc_reg;
        carry_next = carry_reg;
        nc_next    = nc_reg;
        z_next     = z_reg;
        we_next    = 1'b0;
        wa_next    = wa_reg;
        wd_next    = wd_reg;
        if (op_valid_i) begin
            unique case (op)
                ASX_OP_LIT_SUB: begin
                    // literal form always lands in the accumulator
                    acc_next   = diff;
                    carry_next = sub_c;
                    nc_next    = sub_nc;
                    z_next     = is_null(diff);
                end
                ASX_OP_REG_SUB: begin
                    res        = diff;
                    to_reg     = (dest_i == ASX_DEST_REG);
                    carry_next = sub_c;
                    nc_next    = sub_nc;
                    z_next     = is_null(diff);
                end
                ASX_OP_SWAP: begin
                    // flags deliberately untouched
                    res    = {reg_rdata_i[ASX_NIB_LO +: 4],
                              reg_rdata_i[ASX_NIB_HI +: 4]};
                    to_reg = (dest_i == ASX_DEST_REG);
                end
                ASX_OP_REG_XOR: begin
                    res    = acc_reg ^ reg_rdata_i;
                    to_reg = (dest_i == ASX_DEST_REG);
                    z_next = is_null(res);
                end
                ASX_OP_LIT_XOR: begin
                    acc_next = acc_reg ^ literal_i;
                    z_next   = is_null(acc_next);
                end
                default: begin
                    // unknown or idle code: nothing changes
                end
            endcase
            // register-operand forms are routed by the destination bit
            if (op == ASX_OP_REG_SUB || op == ASX_OP_SWAP || op == ASX_OP_REG_XOR) begin
                if (to_reg) begin
                    we_next = 1'b1;
                    wa_next = reg_addr_i;
                    wd_next = res;
                end else begin
                    acc_next = res;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            acc_reg   <= ASX_ACC_RST;
            carry_reg <= ASX_FLAG_RST;
            nc_reg    <= ASX_FLAG_RST;
            z_reg     <= ASX_FLAG_RST;
            we_reg    <= 1'b0;
            wa_reg    <= ASX_ADDR_RST;
            wd_reg    <= ASX_ZERO;
        end else begin
            acc_reg   <= acc_next;
            carry_reg <= carry_next;
            nc_reg    <= nc_next;
            z_reg     <= z_next;
            we_reg    <= we_next;
            wa_reg    <= wa_next;
            wd_reg    <= wd_next;
        end
    end

    // outputs straight from flip-flops
    assign acc_o               = acc_reg;
    assign carry_o             = carry_reg;
    assign nibble_carry_flag_o = nc_reg;
    assign zero_o              = z_reg;
    assign reg_we_o            = we_reg;
    assign reg_waddr_o         = wa_reg;
    assign reg_wdata_o         = wd_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_lit_sub_acc: assert property (op_valid_i && op == ASX_OP_LIT_SUB |=>
        acc_o == 8'($past(literal_i) - $past(acc_o)) && zero_o == (acc_o == 8'h00))
        else $error("literal subtract result wrong");
    a_reg_sub_carry: assert property (op_valid_i && op == ASX_OP_REG_SUB |=>
        carry_o == ($past(reg_rdata_i) >= $past(acc_o)))
        else $error("register subtract carry wrong");
    a_dest_reg_write: assert property (op_valid_i && dest_i &&
        (op == ASX_OP_REG_SUB || op == ASX_OP_SWAP || op == ASX_OP_REG_XOR)
        |=> reg_we_o && reg_waddr_o == $past(reg_addr_i) && $stable(acc_o))
        else $error("destination register write missing");
    a_dest_acc_nowr: assert property (op_valid_i && !dest_i && op == ASX_OP_REG_XOR
        |=> !reg_we_o && acc_o == ($past(acc_o) ^ $past(reg_rdata_i)))
        else $error("accumulator destination wrong");
    a_swap_flags: assert property (op_valid_i && op == ASX_OP_SWAP |=>
        $stable(carry_o) && $stable(zero_o) && $stable(nibble_carry_flag_o))
        else $error("swap changed a flag");
    a_swap_data: assert property (op_valid_i && op == ASX_OP_SWAP && dest_i |=>
        reg_wdata_o == {$past(reg_rdata_i[3:0]), $past(reg_rdata_i[7:4])})
        else $error("swap data wrong");
    a_xor_carry_keep: assert property (op_valid_i && op == ASX_OP_REG_XOR |=>
        $stable(carry_o) && $stable(nibble_carry_flag_o))
        else $error("xor changed carry flags");
    a_lit_xor_zero: assert property (op_valid_i && op == ASX_OP_LIT_XOR |=>
        acc_o == ($past(acc_o) ^ $past(literal_i)) && zero_o == (acc_o == 8'h00))
        else $error("literal xor wrong");
    a_sub_nib_carry: assert property (op_valid_i && op == ASX_OP_REG_SUB |=>
        nibble_carry_flag_o == ($past(reg_rdata_i[3:0]) >= $past(acc_o[3:0])))
        else $error("nibble carry wrong");
    a_we_pulse: assert property (reg_we_o |=> !reg_we_o || $past(op_valid_i))
        else $error("write strobe stuck");

    // the flag and result checks below recompute from sampled operands, so a
    // wrong operand routing into the shared subtractor shows up here too
    a_lit_sub_flags: assert property (op_valid_i && op == ASX_OP_LIT_SUB |=>
        carry_o == ($past(literal_i) >= $past(acc_o)) &&
        nibble_carry_flag_o == ($past(literal_i[3:0]) >= $past(acc_o[3:0])))
        else $error("literal subtract flags wrong");
    a_reg_sub_data: assert property (op_valid_i && op == ASX_OP_REG_SUB && dest_i |=>
        reg_wdata_o == 8'($past(reg_rdata_i) - $past(acc_o)) &&
        zero_o == (reg_wdata_o == 8'h00))
        else $error("register subtract result wrong");
    a_reg_xor_zero: assert property (op_valid_i && op == ASX_OP_REG_XOR && dest_i |=>
        reg_wdata_o == ($past(acc_o) ^ $past(reg_rdata_i)) &&
        zero_o == (reg_wdata_o == 8'h00))
        else $error("register xor result wrong");

    c_sub_zero:  cover property (op_valid_i && op == ASX_OP_REG_SUB ##1 zero_o);
    c_sub_borrow: cover property (op_valid_i && op == ASX_OP_LIT_SUB ##1 !carry_o);
    c_swap_reg:  cover property (op_valid_i && op == ASX_OP_SWAP && dest_i);
    c_back2back: cover property (op_valid_i ##1 op_valid_i);
    c_xor_null:  cover property (op_valid_i && op == ASX_OP_LIT_XOR ##1 zero_o);

endmodule // asx_alu

// ### hdl/asx_pkg.sv
package asx_pkg;

    // ------------------------------------------------------------
    // operand widths and ranges
    // ------------------------------------------------------------
    localparam int unsigned ASX_DATA_W    = 8;               // datapath width
    localparam int unsigned ASX_ADDR_W    = 7;               // file register address width
    localparam logic [6:0]  ASX_ADDR_MAX  = 7'h7f;           // highest file register address
    localparam int unsigned ASX_NIB_LO    = 0;               // low nibble position
    localparam int unsigned ASX_NIB_HI    = 4;               // high nibble position

    // ------------------------------------------------------------
    // destination select codes
    // ------------------------------------------------------------
    localparam logic        ASX_DEST_ACC  = 1'b0;            // result to accumulator
    localparam logic        ASX_DEST_REG  = 1'b1;            // result back to file register

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  ASX_ACC_RST   = 8'h00;           // accumulator after reset
    localparam logic [7:0]  ASX_ZERO      = 8'h00;           // null result pattern
    localparam logic        ASX_FLAG_RST  = 1'b0;            // flags after reset
    localparam logic [6:0]  ASX_ADDR_RST  = 7'h00;           // write-back address after reset

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ASX_OP_NONE    = 3'h0,                               // idle, nothing changes
        ASX_OP_LIT_SUB = 3'h1,                               // literal_minus_acc_op
        ASX_OP_REG_SUB = 3'h2,                               // reg_minus_acc_op
        ASX_OP_SWAP    = 3'h3,                               // nibble_exchange_op
        ASX_OP_REG_XOR = 3'h4,                               // reg_exclusive_or_op
        ASX_OP_LIT_XOR = 3'h5                                // literal_exclusive_or_op
    } asx_op_t;

endpackage

// ### hdl/asx_sub.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two's complement subtractor: minuend - subtrahend
// carry high means no borrow out of bit 7, nibble carry no borrow
// out of bit 3
// ----------------------------------------------------------------
module asx_sub
    import asx_pkg::*;
(
    // operands
    input  wire logic [7:0] minuend_i,
    input  wire logic [7:0] subtrahend_i,
    // results
    output logic      [7:0] diff_o,
    output logic            carry_o,
    output logic            nib_carry_o
);
    logic [8:0] full_sum;    // minuend + ~subtrahend + 1
    logic [4:0] nib_sum;     // same for the low nibble

    // add the inverted subtrahend so carries mean "no borrow"
    always_comb begin
        full_sum    = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + 9'h001;
        nib_sum     = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + 5'h01;
        diff_o      = full_sum[7:0];
        carry_o     = full_sum[8];
        nib_carry_o = nib_sum[4];
    end
endmodule // asx_sub
